// ---- blau_pkg.sv ----
// Purpose: constants and types for the byte lane align unit
// Assumes: 32-bit data path, 30-bit program counter
// Notes:   access size option codes and size type; the decode itself lives in the align unit
package blau_pkg;

   // ***********************************************
   // access size option codes
   // ***********************************************
   localparam logic [2:0] OPT_WORD  = 3'h0;
   localparam logic [2:0] OPT_BYTE  = 3'h1;
   localparam logic [2:0] OPT_HALF  = 3'h2;

   // ***********************************************
   // widths and reset values
   // ***********************************************
   localparam int         DATA_W    = 32;
   localparam int         PC_W      = 30;
   localparam int         PTR_W     = 2;
   localparam logic [1:0] PTR_RST   = 2'h0;
   localparam logic [29:0] PC_RST   = 30'h0000_0000;
   localparam logic [1:0] FETCH_LOW = 2'h0;

   typedef enum logic [1:0] {
      BLAU_SZ_WORD  = 2'b00,
      BLAU_SZ_BYTE  = 2'b01,
      BLAU_SZ_HALF  = 2'b10,
      BLAU_SZ_OTHER = 2'b11
   } blau_size_t;

endpackage

// ---- blau_lane_sel.sv ----
// Purpose: maps a two-bit byte index to a physical lane number
// Assumes: lane 3 is the most significant byte of the word
// Notes:   endianness only changes the index interpretation
`timescale 1ns/1ps
module blau_lane_sel
   import blau_pkg::*;
(
   // index in
   input  wire logic [1:0] byteIdx,
   input  wire logic       endianSelect,
   // lane out
   output logic [1:0]      laneNum,
   output logic            halfUpper
);

   // big endian: index 00 is lane 3; little endian: index 00 is lane 0
   assign laneNum   = endianSelect ? byteIdx : ~byteIdx;
   // bit 0 never enters the half-word choice
   assign halfUpper = endianSelect ? byteIdx[1] : ~byteIdx[1];

endmodule // blau_lane_sel

// ---- blau_misalign_chk.sv ----
// Purpose: unaligned access detection for memory space accesses
// Assumes: checks only while the trap enable is set
// Notes:   combinational, same cycle as the request
`timescale 1ns/1ps
module blau_misalign_chk
   import blau_pkg::*;
(
   // request
   input  wire logic [2:0] accessSizeOptionBits,
   input  wire logic [1:0] addrLow,
   input  wire logic       ioSpace,
   input  wire logic       trapMisalignedEnable,
   // result
   output logic            misalignTrap
);

   logic wordBad;
   logic halfBad;

   assign wordBad = (accessSizeOptionBits == OPT_WORD) && (addrLow != 2'h0);
   assign halfBad = (accessSizeOptionBits == OPT_HALF) && addrLow[0];
   // io space never traps
   assign misalignTrap = trapMisalignedEnable && !ioSpace
                         && (wordBad || halfBad);

endmodule // blau_misalign_chk

// ---- blau_align_unit.sv ----
// Purpose: load/store byte lane selection, extension, replication,
//          write enables, misalignment trap and fetch alignment
// Assumes: one request per accepted cycle; results registered
// Notes:   bus timing and multiple transfers live elsewhere
`timescale 1ns/1ps

module blau_align_unit
   import blau_pkg::*;
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst,
   // configuration
   input  wire logic              endianSelect,
   input  wire logic              trapMisalignedEnable,
   // request from core
   input  wire logic              reqValid,
   input  wire logic              reqStore,
   input  wire logic              reqIoSpace,
   input  wire logic [2:0]        accessSizeOptionBits,
   input  wire logic              signExtendFlag,
   input  wire logic [31:0]       reqAddr,
   input  wire logic              useBytePointer,
   input  wire logic [31:0]       storeSrc,
   // load data from bus
   input  wire logic              loadValid,
   input  wire logic [31:0]       loadWord,
   // program counter control
   input  wire logic              pcLoad,
   input  wire logic [29:0]       pcNew,
   input  wire logic              pcStep,
   // bus request
   output logic                   busStart,
   output logic [31:0]            busAddr,
   output logic [31:0]            busWdata,
   output logic [3:0]             busByteEn,
   output logic                   busWrite,
   // results
   output logic [31:0]            loadResult,
   output logic                   loadDone,
   output logic                   misalignTrap,
   output logic [1:0]             bytePointerField,
   output logic [31:0]            fetchAddr
);

   // ***********************************************
   // decode
   // ***********************************************
   function automatic blau_size_t decodeSize(input logic [2:0] access_size_option);
      case (access_size_option)
         OPT_WORD: decodeSize = BLAU_SZ_WORD;
         OPT_BYTE: decodeSize = BLAU_SZ_BYTE;
         OPT_HALF: decodeSize = BLAU_SZ_HALF;
         default:  decodeSize = BLAU_SZ_OTHER;
      endcase
   endfunction

   blau_size_t reqSize;
   logic [1:0] byteIdx;
   logic [1:0] laneNum;
   logic       halfUpper;
   logic       trapNow;

   assign reqSize = decodeSize(accessSizeOptionBits);
   // pointer field or address bits give the index
   assign byteIdx = useBytePointer ? bytePointerField : reqAddr[1:0];

   blau_lane_sel uLaneSel (
      .byteIdx      (byteIdx),
      .endianSelect (endianSelect),
      .laneNum      (laneNum),
      .halfUpper    (halfUpper)
   );

   blau_misalign_chk uChk (
      .accessSizeOptionBits (accessSizeOptionBits),
      .addrLow              (reqAddr[1:0]),
      .ioSpace              (reqIoSpace),
      .trapMisalignedEnable (trapMisalignedEnable),
      .misalignTrap         (trapNow)
   );

   // ***********************************************
   // store data and byte enables
   // ***********************************************
   logic [31:0] wdataNext;
   logic [3:0]  beNext;

   always_comb begin
      wdataNext = storeSrc;
      beNext    = 4'hF;
      case (reqSize)
         BLAU_SZ_BYTE: begin
            wdataNext = {4{storeSrc[7:0]}};
            beNext    = 4'h1 << laneNum;
         end
         BLAU_SZ_HALF: begin
            wdataNext = {2{storeSrc[15:0]}};
            beNext    = halfUpper ? 4'hC : 4'h3;
         end
         default: begin
            wdataNext = storeSrc;
            beNext    = 4'hF;
         end
      endcase
   end

   // ***********************************************
   // bus request register
   // ***********************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busStart  <= 1'b0;
         busAddr   <= 32'h0000_0000;
         busWdata  <= 32'h0000_0000;
         busByteEn <= 4'h0;
         busWrite  <= 1'b0;
      end else begin
         // trapped accesses are dropped before a cycle begins
         busStart <= reqValid && !trapNow;
         if (reqValid && !trapNow) begin
            busAddr   <= reqAddr;
            busWdata  <= reqStore ? wdataNext : 32'h0000_0000;
            busByteEn <= reqStore ? beNext : 4'hF;
            busWrite  <= reqStore;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         misalignTrap <= 1'b0;
      end else begin
         misalignTrap <= reqValid && trapNow;
      end
   end

   // ***********************************************
   // pending load context
   // ***********************************************
   blau_size_t pendSize_reg;
   logic [1:0] pendLane_reg;
   logic       pendUpper_reg;
   logic       pendSign_reg;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pendSize_reg  <= BLAU_SZ_WORD;
         pendLane_reg  <= 2'h0;
         pendUpper_reg <= 1'b0;
         pendSign_reg  <= 1'b0;
      end else if (reqValid && !reqStore && !trapNow) begin
         pendSize_reg  <= reqSize;
         pendLane_reg  <= laneNum;
         pendUpper_reg <= halfUpper;
         pendSign_reg  <= signExtendFlag;
      end
   end

   // ***********************************************
   // load extraction and extension
   // ***********************************************
   logic [7:0]  selByte;
   logic [15:0] selHalf;
   logic [31:0] loadNext;

   assign selByte = loadWord[{pendLane_reg, 3'b000} +: 8];
   assign selHalf = pendUpper_reg ? loadWord[31:16] : loadWord[15:0];

   always_comb begin
      loadNext = loadWord;
      case (pendSize_reg)
         BLAU_SZ_BYTE: loadNext = {{24{pendSign_reg & selByte[7]}},
                                   selByte};
         BLAU_SZ_HALF: loadNext = {{16{pendSign_reg & selHalf[15]}},
                                   selHalf};
         default:      loadNext = loadWord;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         loadResult <= 32'h0000_0000;
         loadDone   <= 1'b0;
      end else begin
         loadDone <= loadValid;
         if (loadValid) begin
            loadResult <= loadNext;
         end
      end
   end

   // ***********************************************
   // byte pointer update
   // ***********************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bytePointerField <= PTR_RST;
      end else if (reqValid && signExtendFlag) begin
         bytePointerField <= {2{~endianSelect}};
      end
   end

   // ***********************************************
   // program counter and fetch address
   // ***********************************************
   logic [29:0] pc_reg;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pc_reg <= PC_RST;
      end else if (pcLoad) begin
         pc_reg <= pcNew;
      end else if (pcStep) begin
         pc_reg <= pc_reg + 30'h1;
      end
   end

   // external system also ignores the low fetch bits
   assign fetchAddr = {pc_reg, FETCH_LOW};

   // ***********************************************
   // checks
   // ***********************************************
   a_trap_gate: assert property (
      @(posedge core_clk) disable iff (rst)
      reqValid && reqIoSpace |=> !misalignTrap)
      else $error("io access raised trap");
   a_no_trap_bus: assert property (
      @(posedge core_clk) disable iff (rst)
      misalignTrap |-> !busStart)
      else $error("trapped access started bus");
   a_word_trap: assert property (
      @(posedge core_clk) disable iff (rst)
      reqValid && trapMisalignedEnable && !reqIoSpace
      && accessSizeOptionBits == 3'h0 && reqAddr[1:0] != 2'h0
      |=> misalignTrap)
      else $error("word misalign missed");
   a_half_trap: assert property (
      @(posedge core_clk) disable iff (rst)
      reqValid && trapMisalignedEnable && !reqIoSpace
      && accessSizeOptionBits == 3'h2 && reqAddr[0] |=> misalignTrap)
      else $error("half misalign missed");
   a_trap_off: assert property (
      @(posedge core_clk) disable iff (rst)
      !trapMisalignedEnable |=> !misalignTrap)
      else $error("trap while disabled");
   a_store_repl: assert property (
      @(posedge core_clk) disable iff (rst)
      reqValid && reqStore && !trapNow && accessSizeOptionBits == 3'h1
      |=> busWdata == {4{$past(storeSrc[7:0])}})
      else $error("byte not replicated");
   a_half_repl: assert property (
      @(posedge core_clk) disable iff (rst)
      reqValid && reqStore && !trapNow && accessSizeOptionBits == 3'h2
      |=> busWdata == {2{$past(storeSrc[15:0])}})
      else $error("half not replicated");
   a_byte_en: assert property (
      @(posedge core_clk) disable iff (rst)
      reqValid && reqStore && !trapNow && accessSizeOptionBits == 3'h1
      && !useBytePointer && !endianSelect && reqAddr[1:0] == 2'h0
      |=> busByteEn == 4'h8)
      else $error("big endian byte lane wrong");
   a_byte_en_le: assert property (
      @(posedge core_clk) disable iff (rst)
      reqValid && reqStore && !trapNow && accessSizeOptionBits == 3'h1
      && !useBytePointer && endianSelect && reqAddr[1:0] == 2'h0
      |=> busByteEn == 4'h1)
      else $error("little endian byte lane wrong");
   a_byte_en_top: assert property (
      @(posedge core_clk) disable iff (rst)
      reqValid && reqStore && !trapNow && accessSizeOptionBits == 3'h1
      && !useBytePointer && endianSelect && reqAddr[1:0] == 2'h3
      |=> busByteEn == 4'h8)
      else $error("little endian top lane wrong");
   a_half_en: assert property (
      @(posedge core_clk) disable iff (rst)
      reqValid && reqStore && !trapNow && accessSizeOptionBits == 3'h2
      && !useBytePointer && !endianSelect && !reqAddr[1]
      |=> busByteEn == 4'hC)
      else $error("half lane wrong");
   a_half_en_le: assert property (
      @(posedge core_clk) disable iff (rst)
      reqValid && reqStore && !trapNow && accessSizeOptionBits == 3'h2
      && !useBytePointer && endianSelect && !reqAddr[1]
      |=> busByteEn == 4'h3)
      else $error("little endian half lane wrong");
   a_ptr_set: assert property (
      @(posedge core_clk) disable iff (rst)
      reqValid && signExtendFlag
      |=> bytePointerField == {2{$past(~endianSelect)}})
      else $error("byte pointer not set");
   a_ptr_hold: assert property (
      @(posedge core_clk) disable iff (rst)
      !(reqValid && signExtendFlag) |=> $stable(bytePointerField))
      else $error("byte pointer moved");
   a_load_zext: assert property (
      @(posedge core_clk) disable iff (rst)
      loadValid && pendSize_reg == BLAU_SZ_BYTE && !pendSign_reg
      |=> loadResult[31:8] == 24'h00_0000 && loadDone)
      else $error("byte load not zero extended");
   a_load_sext: assert property (
      @(posedge core_clk) disable iff (rst)
      loadValid && pendSize_reg == BLAU_SZ_HALF && pendSign_reg
      |=> loadResult[31:16] == {16{loadResult[15]}} && loadDone)
      else $error("half load not sign extended");
   // reserved codes run as words and must never trap
   a_reserved_opt: assert property (
      @(posedge core_clk) disable iff (rst)
      reqValid && accessSizeOptionBits == 3'h3 |=> !misalignTrap)
      else $error("reserved option trapped");
   a_trap_hold: assert property (
      @(posedge core_clk) disable iff (rst)
      misalignTrap |-> $stable(busAddr) && $stable(busWrite))
      else $error("trapped access changed bus");
   a_fetch_low: assert property (
      @(posedge core_clk) disable iff (rst)
      fetchAddr[1:0] == 2'h0)
      else $error("fetch address unaligned");
   a_fetch_step: assert property (
      @(posedge core_clk) disable iff (rst)
      pcStep && !pcLoad |=> fetchAddr == $past(fetchAddr) + 32'h0000_0004)
      else $error("fetch step wrong");

   c_byte_store: cover property (@(posedge core_clk) disable iff (rst)
      busStart && busWrite && busByteEn == 4'h2);
   c_half_store: cover property (@(posedge core_clk) disable iff (rst)
      busStart && busWrite && busByteEn == 4'h3);
   c_trap: cover property (@(posedge core_clk) disable iff (rst)
      misalignTrap);
   c_sign_load: cover property (@(posedge core_clk) disable iff (rst)
      loadDone && loadResult[31]);
   c_ptr_load: cover property (@(posedge core_clk) disable iff (rst)
      reqValid && useBytePointer && !reqStore);

endmodule // blau_align_unit

// ---- blau_mem_model.sv ----
// Purpose: external memory model on the far side of the align unit
// Assumes: one outstanding load, byte lane 3 is bits 31:24
// Notes:   idle read bus toggles so stale data never looks valid
`timescale 1ns/1ps
module blau_mem_model
   import blau_pkg::*;
#(
   parameter int LAT = 3
)(
   // clock
   input  wire logic        core_clk,
   // bus request
   input  wire logic        busStart,
   input  wire logic [31:0] busAddr,
   input  wire logic [31:0] busWdata,
   input  wire logic [3:0]  busByteEn,
   input  wire logic        busWrite,
   // read answer
   output logic             loadValid,
   output logic [31:0]      loadWord
);
   logic [31:0] memArr [16];
   logic [3:0]  rdIdx;
   int          waitCnt = 0;

   initial begin
      loadValid = 1'b0;
      loadWord  = 32'h0000_0000;
   end

   // word index only: low address bits never matter here
   always @(posedge core_clk) begin
      loadValid <= 1'b0;
      loadWord  <= ~loadWord;
      if (waitCnt == 1) begin
         loadValid <= 1'b1;
         loadWord  <= memArr[rdIdx];
      end
      if (waitCnt > 0) begin
         waitCnt <= waitCnt - 1;
      end
      if (busStart) begin
         rdIdx <= busAddr[5:2];
         if (busWrite) begin
            for (int i = 0; i < 4; i++) begin
               if (busByteEn[i]) begin
                  memArr[busAddr[5:2]][8*i+:8] <= busWdata[8*i+:8];
               end
            end
         end else begin
            // address bit 2 makes a slow answer
            waitCnt <= busAddr[2] ? LAT + 2 : LAT;
         end
      end
   end
endmodule // blau_mem_model

// ---- blau_align_unit_test.sv ----
// Purpose: self-checking bench for the byte lane align unit
// Assumes: inputs driven at falling edge, results one cycle later
// Notes:   memory model answers loads
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin \
   fails++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module blau_align_unit_test;
   import blau_pkg::*;
   logic core_clk = 0, rst = 1, endianSelect = 0, trapMisalignedEnable = 0;
   logic reqValid = 0, reqStore = 0, reqIoSpace = 0, signExtendFlag = 0;
   logic useBytePointer = 0, loadValid, pcLoad = 0, pcStep = 0;
   logic [2:0]  accessSizeOptionBits = 3'h0;
   logic [31:0] reqAddr = 32'h0000_0000, storeSrc = 32'h0000_0000;
   logic [31:0] loadWord, busAddr, busWdata, loadResult, fetchAddr;
   logic [29:0] pcNew = 30'h0000_0000;
   logic [3:0]  busByteEn;
   logic [1:0]  bytePointerField;
   logic        busStart, busWrite, loadDone, misalignTrap;
   int          fails = 0, nCompared = 0, cyc = 0;
   localparam logic [31:0] MEM_W = 32'h80FF_7F01;

   initial forever #50 core_clk = ~core_clk;

   blau_align_unit uut (.core_clk(core_clk), .rst(rst),
      .endianSelect(endianSelect),
      .trapMisalignedEnable(trapMisalignedEnable), .reqValid(reqValid),
      .reqStore(reqStore), .reqIoSpace(reqIoSpace),
      .accessSizeOptionBits(accessSizeOptionBits),
      .signExtendFlag(signExtendFlag), .reqAddr(reqAddr),
      .useBytePointer(useBytePointer), .storeSrc(storeSrc),
      .loadValid(loadValid), .loadWord(loadWord), .pcLoad(pcLoad),
      .pcNew(pcNew), .pcStep(pcStep), .busStart(busStart),
      .busAddr(busAddr), .busWdata(busWdata), .busByteEn(busByteEn),
      .busWrite(busWrite), .loadResult(loadResult), .loadDone(loadDone),
      .misalignTrap(misalignTrap), .bytePointerField(bytePointerField),
      .fetchAddr(fetchAddr));

   blau_mem_model #(.LAT(3)) mem (.core_clk(core_clk),
      .busStart(busStart), .busAddr(busAddr), .busWdata(busWdata),
      .busByteEn(busByteEn), .busWrite(busWrite),
      .loadValid(loadValid), .loadWord(loadWord));

   function automatic logic [1:0] ln(logic [1:0] i, logic le);
      return le ? i : ~i;
   endfunction

   task automatic req(logic st, logic io, logic [2:0] access_size_option, logic sx,
                      logic [31:0] a, logic [31:0] src);
      @(negedge core_clk);
      {reqValid, reqStore, reqIoSpace} = {1'b1, st, io};
      {accessSizeOptionBits, signExtendFlag} = {access_size_option, sx};
      {reqAddr, storeSrc} = {a, src};
      @(negedge core_clk);
      reqValid = 1'b0;
   endtask

   task automatic wait_ld();
      int k = 0;
      while (loadDone !== 1'b1 && k < 20) begin
         @(negedge core_clk);
         k++;
      end
      `CHK("loadDone", 1'b1, loadDone)
   endtask

   task automatic t_store();
      logic [1:0] l;
      for (int e = 0; e < 2; e++) for (int a = 0; a < 4; a++) begin
         endianSelect = e[0];
         l = ln(a[1:0], e[0]);
         req(1, 0, OPT_BYTE, 0, 32'h0000_0010 + a, 32'h1234_56AB);
         `CHK("busStart", 1'b1, busStart)
         `CHK("wdata b", 32'hABAB_ABAB, busWdata)
         `CHK("be b", 4'h1 << l, busByteEn)
         req(1, 0, OPT_HALF, 0, 32'h0000_0010 + a, 32'h1234_56AB);
         `CHK("wdata h", 32'h56AB_56AB, busWdata)
         `CHK("be h", l[1] ? 4'hC : 4'h3, busByteEn)
      end
      req(1, 0, OPT_WORD, 0, 32'h0000_0020, MEM_W);
      `CHK("be w", 4'hF, busByteEn)
      `CHK("wr w", 1'b1, busWrite)
      $display("done t_store");
   endtask

   task automatic t_load();
      logic [1:0] l;
      logic [15:0] it;
      for (int e = 0; e < 2; e++) for (int a = 0; a < 8; a++)
      for (int sx = 0; sx < 2; sx++) begin
         endianSelect = e[0];
         l = ln(a[1:0], e[0]);
         it = a[2] ? (l[1] ? MEM_W[31:16] : MEM_W[15:0])
                   : {{8{sx[0] & MEM_W[8*l+7]}}, MEM_W[8*l+:8]};
         req(0, 0, a[2] ? OPT_HALF : OPT_BYTE, sx[0],
             32'h0000_0020 + a[1:0], 32'h0000_0000);
         wait_ld();
         `CHK("ld", {{16{sx[0] & it[15]}}, it}, loadResult)
         if (sx) `CHK("ptr", {2{~e[0]}}, bytePointerField)
      end
      endianSelect = 0;
      req(0, 0, OPT_BYTE, 1, 32'h0000_0020, 32'h0000_0000);
      wait_ld();
      useBytePointer = 1;
      req(0, 0, OPT_BYTE, 0, 32'h0000_0020, 32'h0000_0000);
      wait_ld();
      useBytePointer = 0;
      `CHK("ld ptr", 32'h0000_0001, loadResult)
      $display("done t_load");
   endtask

   task automatic chk_trap(logic st, logic io, logic tu, logic [2:0] access_size_option,
                           logic [1:0] a, logic ex);
      logic [31:0] prev;
      trapMisalignedEnable = tu;
      prev = busAddr;
      req(st, io, access_size_option, 0, 32'h0000_0044 + a, 32'h0000_0000);
      `CHK("trap", ex, misalignTrap)
      `CHK("start", ~ex, busStart)
      if (ex) `CHK("addr held", prev, busAddr)
      if (!ex && !st) wait_ld();
   endtask

   task automatic t_trap();
      for (int a = 1; a < 4; a++) chk_trap(0, 0, 1, OPT_WORD, a, 1);
      chk_trap(1, 0, 1, OPT_WORD, 2, 1);
      chk_trap(0, 0, 1, OPT_HALF, 1, 1);
      chk_trap(0, 0, 1, OPT_HALF, 3, 1);
      chk_trap(0, 0, 1, OPT_HALF, 2, 0);
      chk_trap(0, 0, 1, OPT_BYTE, 3, 0);
      chk_trap(0, 0, 1, 3'h3, 1, 0);
      chk_trap(0, 1, 1, OPT_WORD, 1, 0);
      chk_trap(0, 0, 0, OPT_WORD, 2, 0);
      $display("done t_trap");
   endtask

   task automatic t_pc();
      {pcLoad, pcNew} = {1'b1, 30'h3FFF_FFFF};
      @(negedge core_clk);
      {pcLoad, pcStep} = 2'b01;
      `CHK("fetch", 32'hFFFF_FFFC, fetchAddr)
      @(negedge core_clk);
      {pcLoad, pcStep, pcNew} = {2'b11, 30'h0000_0005};
      `CHK("fetch wrap", 32'h0000_0000, fetchAddr)
      @(negedge core_clk);
      {pcLoad, pcStep} = 2'b00;
      `CHK("fetch load", 32'h0000_0014, fetchAddr)
      $display("done t_pc");
   endtask

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", nCompared, fails);
      if (fails == 0 && nCompared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard, far above the few hundred cycles needed
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end

   initial begin
      repeat (5) @(negedge core_clk);
      rst = 0;
      `CHK("rst fetch", 32'h0000_0000, fetchAddr)
      `CHK("rst ptr", 2'h0, bytePointerField)
      t_store();
      t_load();
      t_trap();
      t_pc();
      report_and_stop();
   end
endmodule // blau_align_unit_test
